/* File: include/fifo_flag_pkg.sv */
// Constants shared by the dual-clock FIFO flag logic.
// Assumes a single fast system clock that samples both FIFO clock pins.
package fifo_flag_pkg;

  // Documented geometry: 36-bit words, 2**16 or 2**17 words deep
  localparam int DATA_W_DEF  = 36;
  localparam int ADDR_W_DEF  = 16;

  // Two flip-flops before any logic reads an outside pin
  localparam int SYNC_STAGES = 2;

  // Timing mode, one-hot, latched during master reset
  typedef enum logic [1:0] {
    MODE_STANDARD = 2'b01,
    MODE_FALL_THROUGH_MODE     = 2'b10
  } mode_e;

  // Flag levels after master reset (all flags are active low)
  localparam logic EMPTY_RST     = 1'b0;  // Empty flag asserted
  localparam logic FULL_RST      = 1'b1;  // Full flag clear
  localparam logic OUT_READY_RST = 1'b1;  // No valid word at outputs
  localparam logic IN_READY_RST  = 1'b0;  // Room for writing
  localparam logic ALM_EMPTY_RST = 1'b0;  // Almost-empty asserted
  localparam logic ALM_FULL_RST  = 1'b1;  // Almost-full clear
  localparam logic HALF_FULL_RST = 1'b1;  // Half-full clear

  // Extra word held in the output register in fall-through mode
  localparam int FALL_THROUGH_MODE_EXTRA  = 1;

endpackage

/* File: hw/fifo_flag_core.sv */
// Dual-clock FIFO storage, read modes and status flags.
// Assumes write and read clocks are pins far slower than MCLK; MCLK
// samples them and acts on their rising edges.
`timescale 1ns/1ps

// What this block does
// - Low select at master reset picks standard mode
// - High select at master reset picks fall-through
// - Fall-through first word flagged ready after three read edges
// - Word captured each write edge with enable low, unless full
// - Standard empty flag rises after first write
// - Standard almost-empty high from n+1 words
// - Standard half-full low from half plus one
// - Standard almost-full low from depth minus m
// - Standard full low at depth, read clears
// - Standard almost-empty low at n words
// - Standard empty low after last read, reads ignored
// - Standard empty and full double registered
// - Fall-through output-ready low after first write
// - Fall-through almost-empty high from n+2 words
// - Fall-through half-full low from half plus two
// - Fall-through almost-full low from depth+1 minus m
// - Fall-through input-ready high at depth plus one
// - Fall-through read from full lowers input-ready
// - Fall-through almost-empty low at n+1 words
// - Fall-through output-ready high after last read
// - Output-ready triple, input-ready double registered
// - Offsets range zero to depth minus one
module fifo_flag_core
  import fifo_flag_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,    // Word width
  parameter int ADDR_W = ADDR_W_DEF     // Log2 of memory depth
) (
  input  wire logic              MCLK,                          // System clock
  input  wire logic              NRST,                          // Async reset
  input  wire logic              MASTER_RESET_N,                // FIFO reset pin
  input  wire logic              FALL_THROUGH_SELECT_SERIAL_IN, // Mode strap
  input  wire logic              WCLK,                          // Write clock
  input  wire logic              WRITE_EN_N,                    // Write enable
  input  wire logic [DATA_W-1:0] DATA_IN,                       // Write data
  input  wire logic              RCLK,                          // Read clock
  input  wire logic              READ_EN_N,                     // Read enable
  input  wire logic [ADDR_W-1:0] EMPTY_OFFSET,                  // Offset n
  input  wire logic [ADDR_W-1:0] FULL_OFFSET,                   // Offset m
  output logic      [DATA_W-1:0] DATA_OUT,                      // Read data
  output logic                   EMPTY_FLAG_N,                  // Standard
  output logic                   FULL_FLAG_N,                   // Standard
  output logic                   OUTPUT_READY_N,                // Fall-through
  output logic                   INPUT_READY_N,                 // Fall-through
  output logic                   ALMOST_EMPTY_FLAG_N,           // Both modes
  output logic                   ALMOST_FULL_FLAG_N,            // Both modes
  output logic                   HALF_FULL_FLAG_N,              // Both modes
  output logic                   FALL_THROUGH_MODE              // Latched mode
);

  localparam int DEPTH = 1 << ADDR_W;              // Memory words
  localparam int PIN_W = DATA_W + 2*ADDR_W + 6;    // Sampled pin bundle
  localparam int CNT_W = ADDR_W + 2;               // Count incl. out reg
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);       // Full memory
  localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2);   // Half point
  localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);           // Unit step

  // Pin synchroniser: stage one feeds only stage two
  logic [PIN_W-1:0]  pin_s1_ff;                    // First stage
  logic [PIN_W-1:0]  pin_s2_ff;                    // Second stage
  logic [PIN_W-1:0]  pin_bus;                      // Raw pins

  assign pin_bus = {MASTER_RESET_N, FALL_THROUGH_SELECT_SERIAL_IN, WCLK,
                    WRITE_EN_N, RCLK, READ_EN_N, EMPTY_OFFSET, FULL_OFFSET,
                    DATA_IN};

  // Two flip-flops for every outside input; data and enables stay aligned
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= pin_bus;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Unpacked view of the synchronised pins
  wire              mrs_n  = pin_s2_ff[PIN_W-1];           // Master reset
  wire              fsel   = pin_s2_ff[PIN_W-2];           // Mode strap
  wire              wclk_s = pin_s2_ff[PIN_W-3];           // Write clock
  wire              wen_n  = pin_s2_ff[PIN_W-4];           // Write enable
  wire              rclk_s = pin_s2_ff[PIN_W-5];           // Read clock
  wire              ren_n  = pin_s2_ff[PIN_W-6];           // Read enable
  wire [ADDR_W-1:0] off_n  = pin_s2_ff[DATA_W+2*ADDR_W-1 -: ADDR_W];
  wire [ADDR_W-1:0] off_m  = pin_s2_ff[DATA_W+ADDR_W-1 -: ADDR_W];
  wire [DATA_W-1:0] din    = pin_s2_ff[DATA_W-1:0];        // Write word

  // Edge finders on the sampled clocks
  logic wclk_d_ff;                                 // Delayed write clock
  logic rclk_d_ff;                                 // Delayed read clock
  wire  wr_edge = wclk_s & ~wclk_d_ff;             // Write clock rise
  wire  rd_edge = rclk_s & ~rclk_d_ff;             // Read clock rise

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wclk_d_ff <= 1'b0;
      rclk_d_ff <= 1'b0;
    end else begin
      wclk_d_ff <= wclk_s;
      rclk_d_ff <= rclk_s;
    end
  end

  // Mode is caught while master reset is held; NRST loads standard mode
  mode_e mode_ff;                                  // Latched timing mode
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mode_ff <= MODE_STANDARD;
    end else if (!mrs_n) begin
      mode_ff <= fsel ? MODE_FALL_THROUGH_MODE : MODE_STANDARD;
    end
  end
  wire fall_through_mode = (mode_ff == MODE_FALL_THROUGH_MODE);              // Fall-through active

  // Storage and pointers; pointer MSB tells full from empty
  logic [DATA_W-1:0] mem_ff [DEPTH];               // Word storage
  logic [ADDR_W:0]   wptr_ff;                      // Write pointer
  logic [ADDR_W:0]   rptr_ff;                      // Read pointer
  logic [DATA_W-1:0] dout_ff;                      // Output register
  logic              out_valid_ff;                 // Output reg holds word
  logic              empty_ff, empty_s1_ff;        // Empty flag stages
  logic              full_ff, full_s1_ff;          // Full flag stages
  logic              ordy_ff, ordy_s1_ff;          // Output-ready stages
  logic              irdy_ff, irdy_s1_ff;          // Input-ready stages
  logic              pae_ff, paf_ff, hf_ff;        // Level flags

  wire [ADDR_W:0] mem_cnt  = wptr_ff - rptr_ff;    // Words in memory
  wire            mem_full = (mem_cnt == DEPTH_C[ADDR_W:0]);
  wire            mem_any  = (mem_cnt != '0);

  // Writes are refused once the outward full indication is shown
  wire wr_room = fall_through_mode ? ~irdy_ff : full_ff;
  wire wr_do   = wr_edge & ~wen_n & wr_room & ~mem_full;

  // Standard read: each word needs read enable; empty ignores it
  wire rd_std  = ~fall_through_mode & rd_edge & ~ren_n & empty_ff & mem_any;

  // Fall-through: a read consumes the shown word; refill needs no enable
  wire take    = fall_through_mode & rd_edge & ~ren_n & ~ordy_ff & out_valid_ff;
  wire keep    = out_valid_ff & ~take;             // Word still shown
  wire refill  = fall_through_mode & rd_edge & ~keep & mem_any;
  wire rd_do   = rd_std | refill;                  // Memory pop

  // Next memory count, used so flags reflect this edge's own transfer
  wire [ADDR_W:0] cnt_nxt = mem_cnt + {{ADDR_W{1'b0}}, wr_do}
                                    - {{ADDR_W{1'b0}}, rd_do};

  // Memory write port: one word per write clock rise
  always_ff @(posedge MCLK) begin
    if (wr_do) begin
      mem_ff[wptr_ff[ADDR_W-1:0]] <= din;
    end
  end

  // Pointers and output register; master reset empties the FIFO
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      wptr_ff      <= '0;
      rptr_ff      <= '0;
      dout_ff      <= '0;
      out_valid_ff <= 1'b0;
    end else if (!mrs_n) begin
      wptr_ff      <= '0;
      rptr_ff      <= '0;
      dout_ff      <= '0;
      out_valid_ff <= 1'b0;
    end else begin
      if (wr_do) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (rd_do) begin
        rptr_ff <= rptr_ff + 1'b1;
        dout_ff <= mem_ff[rptr_ff[ADDR_W-1:0]];
      end
      if (fall_through_mode && rd_edge) begin
        out_valid_ff <= keep | refill;
      end
    end
  end

  // Read-side handshake flags move only on read clock rises.
  // Out-valid is the first of three output-ready stages, so the first
  // word loads on the first read edge after the write, its flag on the third.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      empty_s1_ff <= EMPTY_RST;
      empty_ff    <= EMPTY_RST;
      ordy_s1_ff  <= OUT_READY_RST;
      ordy_ff     <= OUT_READY_RST;
    end else if (!mrs_n) begin
      empty_s1_ff <= EMPTY_RST;
      empty_ff    <= EMPTY_RST;
      ordy_s1_ff  <= OUT_READY_RST;
      ordy_ff     <= OUT_READY_RST;
    end else if (rd_edge) begin
      if (!fall_through_mode) begin
        empty_s1_ff <= (cnt_nxt != '0);
        empty_ff    <= empty_s1_ff;
      end else begin
        ordy_s1_ff  <= ~out_valid_ff;
        ordy_ff     <= ordy_s1_ff;
      end
    end
  end

  // Write-side handshake flags move only on write clock rises
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      full_s1_ff <= FULL_RST;
      full_ff    <= FULL_RST;
      irdy_s1_ff <= IN_READY_RST;
      irdy_ff    <= IN_READY_RST;
    end else if (!mrs_n) begin
      full_s1_ff <= FULL_RST;
      full_ff    <= FULL_RST;
      irdy_s1_ff <= IN_READY_RST;
      irdy_ff    <= IN_READY_RST;
    end else if (wr_edge) begin
      if (!fall_through_mode) begin
        full_s1_ff <= (cnt_nxt != DEPTH_C[ADDR_W:0]);
        full_ff    <= full_s1_ff;
      end else begin
        irdy_s1_ff <= (cnt_nxt == DEPTH_C[ADDR_W:0]);
        irdy_ff    <= irdy_s1_ff;
      end
    end
  end

  // Total stored words: the output register counts in fall-through
  wire [CNT_W-1:0] extra = fall_through_mode ? CNT_W'(FALL_THROUGH_MODE_EXTRA) : '0;
  wire [CNT_W-1:0] total = CNT_W'(mem_cnt) + ((fall_through_mode & out_valid_ff)
                                              ? ONE_C : '0);

  // Thresholds shift by one word in fall-through mode.
  // Offsets are taken as given; values above depth-1 are not checked.
  wire [CNT_W-1:0] pae_lvl = CNT_W'(off_n) + ONE_C + extra;
  wire [CNT_W-1:0] hf_lvl  = HALF_C + ONE_C + extra;
  wire [CNT_W-1:0] paf_lvl = DEPTH_C + extra - CNT_W'(off_m);

  wire pae_nxt = (total >= pae_lvl);
  wire hf_nxt  = ~(total >= hf_lvl);
  wire paf_nxt = ~(total >= paf_lvl);

  // Level flags follow the count with one register of delay
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      pae_ff <= ALM_EMPTY_RST;
      hf_ff  <= HALF_FULL_RST;
      paf_ff <= ALM_FULL_RST;
    end else if (!mrs_n) begin
      pae_ff <= ALM_EMPTY_RST;
      hf_ff  <= HALF_FULL_RST;
      paf_ff <= ALM_FULL_RST;
    end else begin
      pae_ff <= pae_nxt;
      hf_ff  <= hf_nxt;
      paf_ff <= paf_nxt;
    end
  end

  // Outputs from registers, except FALL_THROUGH_MODE, which is decoded from mode_ff
  assign DATA_OUT            = dout_ff;
  assign EMPTY_FLAG_N        = empty_ff;
  assign FULL_FLAG_N         = full_ff;
  assign OUTPUT_READY_N      = ordy_ff;
  assign INPUT_READY_N       = irdy_ff;
  assign ALMOST_EMPTY_FLAG_N = pae_ff;
  assign ALMOST_FULL_FLAG_N  = paf_ff;
  assign HALF_FULL_FLAG_N    = hf_ff;
  assign FALL_THROUGH_MODE   = fall_through_mode;

  // Checks on the flag behaviour

  AST_MODE_LOCK: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && $past(mrs_n) |-> $stable(mode_ff))
    else $error("mode changed outside master reset");

  AST_MODE_FALL_THROUGH_MODE: assert property (@(posedge MCLK) disable iff (!NRST)
    !mrs_n && fsel |=> fall_through_mode)
    else $error("high strap did not select fall-through");

  AST_NO_RD_EMPTY: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && !fall_through_mode && !empty_ff |=> $stable(rptr_ff))
    else $error("read taken while empty flag asserted");

  AST_NO_WR_FULL: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && ((!fall_through_mode && !full_ff) || (fall_through_mode && irdy_ff)) |=> $stable(wptr_ff))
    else $error("write taken while full");

  AST_EMPTY_PIPE: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && !fall_through_mode && rd_edge && cnt_nxt != '0 ##1 (!rd_edge)[*1]
    ##0 mrs_n |-> empty_s1_ff)
    else $error("empty first stage missed a stored word");

  AST_ORDY_CAUSE: assert property (@(posedge MCLK) disable iff (!NRST)
    fall_through_mode && mrs_n && $fell(ordy_ff) |-> !$past(ordy_s1_ff))
    else $error("output-ready fell without its earlier stage");

  AST_IRDY_CAUSE: assert property (@(posedge MCLK) disable iff (!NRST)
    fall_through_mode && $rose(irdy_ff) |-> $past(irdy_s1_ff) && mem_full)
    else $error("input-ready rose while memory not full");

  AST_HALF_LVL: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && $past(mrs_n) |-> hf_ff == ($past(total) < $past(hf_lvl)))
    else $error("half-full flag disagrees with count");

  AST_PAE_LVL: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && $past(mrs_n) |-> pae_ff == ($past(total) >= $past(pae_lvl)))
    else $error("almost-empty flag disagrees with count");

  AST_PAF_LVL: assert property (@(posedge MCLK) disable iff (!NRST)
    mrs_n && $past(mrs_n) |-> paf_ff == ($past(total) < $past(paf_lvl)))
    else $error("almost-full flag disagrees with count");

  AST_FT_SHOWN: assert property (@(posedge MCLK) disable iff (!NRST)
    fall_through_mode && $fell(ordy_ff) |-> out_valid_ff)
    else $error("output-ready fell with no word to show");

endmodule // fifo_flag_core

/* File: verif/fifo_agents.sv */
// Writing and reading agents that face the FIFO pins.
// Assumes MCLK is the 4 ns system clock; FIFO clocks run at 160 ns.
`timescale 1ns/1ps
module fifo_agents
  import fifo_flag_pkg::*;
(
  input  wire logic                  MCLK,       // System clock
  output logic                       WCLK,       // Write clock, still
  output logic                       WRITE_EN_N, // Write enable
  output logic [DATA_W_DEF-1:0]      DATA_IN,    // Write word
  output logic                       RCLK,       // Read clock, still
  output logic                       READ_EN_N   // Read enable
);
  // Idle pins: clocks stand still between transfers, enables off
  initial begin
    WCLK       = 1'b0;
    RCLK       = 1'b0;
    WRITE_EN_N = 1'b1;
    READ_EN_N  = 1'b1;
    DATA_IN    = '0;
  end

  // Wait n system clocks, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // One write clock period; a high enable only clocks the flags
  task automatic put_word(input logic en_n, input logic [35:0] d);
    tick(1);
    WRITE_EN_N = en_n;
    DATA_IN    = d;
    tick(10);
    WCLK = 1'b1;
    tick(20);
    WCLK       = 1'b0;
    WRITE_EN_N = 1'b1;
    // Released bus shows the inverse, never a stale word
    DATA_IN    = ~d;
    tick(9);
  endtask

  // One read clock period; a high enable only clocks the flags and the fall-through refill
  task automatic pull(input logic en_n);
    tick(1);
    READ_EN_N = en_n;
    tick(10);
    RCLK = 1'b1;
    tick(20);
    RCLK      = 1'b0;
    READ_EN_N = 1'b1;
    tick(9);
  endtask
endmodule // fifo_agents

/* File: verif/tb_top.sv */
// Self-checking bench for the FIFO flag core in both timing modes.
// Assumes a 16-word core and the agents model on the FIFO pins.
`timescale 1ns/1ps
module tb_top
  import fifo_flag_pkg::*;
;
  localparam int AW    = 4;       // Short depth keeps the run brief
  localparam int DEPTH = 1 << AW; // Memory words
  int          n_ofs;             // Empty offset n in use
  int          m_ofs;             // Full offset m in use

  logic        mclk, nrst, master_reset_n, sel;  // Clock and resets
  logic        wclk, wen_n, rclk, ren_n;         // Agent pins
  logic [35:0] din, data_out;                    // Data paths
  logic        ef_n, ff_n, or_n, ir_n, ftm;      // Flags and mode
  logic        pae_n, paf_n, hf_n;               // Level flags
  logic [AW-1:0] e_ofs, f_ofs;                   // Offsets
  int          errors, tests_run;                // Tallies

  fifo_agents agents (.MCLK(mclk), .WCLK(wclk), .WRITE_EN_N(wen_n),
    .DATA_IN(din), .RCLK(rclk), .READ_EN_N(ren_n));

  fifo_flag_core #(.DATA_W(36), .ADDR_W(AW)) dut (.MCLK(mclk),
    .NRST(nrst), .MASTER_RESET_N(master_reset_n),
    .FALL_THROUGH_SELECT_SERIAL_IN(sel), .WCLK(wclk),
    .WRITE_EN_N(wen_n), .DATA_IN(din), .RCLK(rclk), .READ_EN_N(ren_n),
    .EMPTY_OFFSET(e_ofs), .FULL_OFFSET(f_ofs), .DATA_OUT(data_out),
    .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n), .OUTPUT_READY_N(or_n),
    .INPUT_READY_N(ir_n), .ALMOST_EMPTY_FLAG_N(pae_n),
    .ALMOST_FULL_FLAG_N(paf_n), .HALF_FULL_FLAG_N(hf_n),
    .FALL_THROUGH_MODE(ftm));

  // Compare one value, four-state exact
  task automatic check(input string what, input logic [35:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Distinct word per index
  function automatic logic [35:0] word(input int i);
    return {20'h5a5a3, 16'(i)};
  endfunction

  // Master reset with the mode strap held at s
  task automatic mreset(input logic s);
    @(posedge mclk);
    #1;
    sel            = s;
    master_reset_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    master_reset_n = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // Standard mode: fill past full, then drain past empty
  task automatic test_std;
    int i;
    mreset(1'b0);
    check("mode", ftm, 1'b0);
    check("or_idle", or_n, 1'b1);
    for (i = 1; i <= DEPTH + 1; i++) begin
      agents.put_word(1'b0, word(i));
      check("std_pae", pae_n, i > n_ofs);
      check("std_hf", hf_n, i < DEPTH / 2 + 1);
      check("std_paf", paf_n, i < DEPTH - m_ofs);
      if (i == DEPTH) check("std_ff_lag", ff_n, 1'b1);
    end
    check("std_ff", ff_n, 1'b0);
    check("std_ef_frozen", ef_n, 1'b0);
    agents.pull(1'b1);
    check("std_ef_lag", ef_n, 1'b0);
    agents.pull(1'b1);
    check("std_ef", ef_n, 1'b1);
    for (i = 1; i <= DEPTH + 1; i++) begin
      agents.pull(1'b0);
      // Read past empty must leave the last word in place
      check("std_data", data_out, word(i > DEPTH ? DEPTH : i));
      check("std_pae_drain", pae_n, DEPTH - i > n_ofs);
      if (i == 1) begin
        agents.put_word(1'b1, '0);
        agents.put_word(1'b1, '0);
        check("std_ff_clear", ff_n, 1'b1);
      end
    end
    check("std_ef_empty", ef_n, 1'b0);
    $display("test_std done");
  endtask

  // Fall-through mode: first word falls through, fill, drain
  task automatic test_fall_through_mode;
    int i;
    mreset(1'b1);
    check("mode", ftm, 1'b1);
    check("ef_idle", ef_n, 1'b0);
    check("ir_idle", ir_n, 1'b0);
    // New offsets while quiet: n raised, m at its floor of zero
    n_ofs = 5;
    m_ofs = 0;
    e_ofs = AW'(n_ofs);
    f_ofs = AW'(m_ofs);
    agents.put_word(1'b0, word(1));
    agents.pull(1'b1);
    agents.pull(1'b1);
    check("ft_or_lag", or_n, 1'b1);
    agents.pull(1'b1);
    check("ft_or", or_n, 1'b0);
    check("ft_first", data_out, word(1));
    for (i = 2; i <= DEPTH + 2; i++) begin
      agents.put_word(1'b0, word(i));
      check("ft_pae", pae_n, i > n_ofs + 1);
      check("ft_hf", hf_n, i < DEPTH / 2 + 2);
      check("ft_paf", paf_n, i < DEPTH + 1 - m_ofs);
      if (i == DEPTH + 1) check("ft_ir_lag", ir_n, 1'b0);
    end
    check("ft_ir", ir_n, 1'b1);
    for (i = 1; i <= DEPTH + 1; i++) begin
      agents.pull(1'b0);
      // The last word stays shown once the memory has run dry
      check("ft_data", data_out, word(i > DEPTH ? DEPTH + 1 : i + 1));
      check("ft_pae_drain", pae_n, DEPTH + 1 - i > n_ofs + 1);
      if (i == 1) begin
        agents.put_word(1'b1, '0);
        agents.put_word(1'b1, '0);
        check("ft_ir_clear", ir_n, 1'b0);
      end
    end
    // Reads on an empty FIFO are ignored while the flag catches up
    agents.pull(1'b0);
    agents.pull(1'b0);
    check("ft_or_empty", or_n, 1'b1);
    $display("test_fall_through_mode done");
  endtask

  // Mid-run system reset: read word and mode drop at once, and the
  // synchroniser's reset state must not latch a stray mode afterwards
  task automatic test_nrst;
    @(posedge mclk);
    #1;
    nrst = 1'b0;
    #1;
    check("nrst_data", data_out, 36'h0);
    check("nrst_mode", ftm, 1'b0);
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    check("nrst_mode_kept", ftm, 1'b0);
    check("nrst_or", or_n, 1'b1);
    $display("test_nrst done");
  endtask

  // Counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // 250 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    errors         = 0;
    tests_run      = 0;
    nrst           = 1'b0;
    master_reset_n = 1'b0;
    sel            = 1'b0;
    n_ofs          = 2;
    m_ofs          = 3;
    e_ofs          = AW'(n_ofs);
    f_ofs          = AW'(m_ofs);
    repeat (4) @(posedge mclk);
    #1;
    nrst = 1'b1;
    test_std();
    test_fall_through_mode();
    test_nrst();
    print_verdict();
  end

  // Watchdog: about six times the expected run
  initial begin
    #80000;
    errors++;
    $display("Error watchdog expected done seen hang");
    print_verdict();
  end
endmodule // tb_top
